// File: src/door_supervision_consts.vh
`ifndef DOOR_SUPERVISION_CONSTS_VH
`define DOOR_SUPERVISION_CONSTS_VH
// clock and timebase
`define CLK_HZ            50000000
`define TICK_MS           100
`define TICK_CYCLES       (`CLK_HZ / 1000 * `TICK_MS)
`define TICKS_PER_SEC     10
// apb register byte offsets
`define REG_CTRL          12'h000
`define REG_LOCK_TIME     12'h004
`define REG_ALARM_TIME    12'h008
`define REG_PRE_PULSE     12'h00C
`define REG_LEFT_PULSE    12'h010
`define REG_FORCED_PULSE  12'h014
`define REG_CMD           12'h018
`define REG_STATUS        12'h01C
`define REG_IRQ_STATUS    12'h020
`define REG_IRQ_MASK      12'h024
// ctrl fields
`define CTRL_INVERT_DOOR  0
`define CTRL_SLAVE_ALL    1
`define CTRL_SLAVE_ASSIGN 2
`define CTRL_INTERLOCK    3
`define CTRL_EXIT_TIME_EN 4
// cmd fields (write strobes)
`define CMD_CRED_UNLOCK   0
`define CMD_MANUAL_UNLOCK 1
`define CMD_LOCK          2
`define CMD_SLAVE_RIGHTS  3
// irq / status event bits
`define EV_PRE            0
`define EV_LEFT           1
`define EV_FORCED         2
`define EV_OPEN           3
`define EV_CLOSE          4
// reset values and lock time ceiling
`define RST_LOCK_TIME     8'h05
`define RST_EXIT_TIME     8'h05
`define RST_PRE_DELAY     8'h1E
`define RST_LEFT_DELAY    8'h2D
`define RST_FORCED_DELAY  8'h00
`define MAX_LOCK_TIME     8'h80
`endif

// File: src/door_supervision_timers.v
// Notes on behaviour
// RULE_01: door open pre-alarm delay raises pre-alarm
// RULE_02: left-open time raises alarm, trouble, output
// RULE_03: left-open timer starts at door opening
// RULE_04: defaults 30 s pre-alarm, 45 s left-open
// RULE_05: schedule edges latch unlock and lock
// RULE_06: slave door follows primary if user allowed
// RULE_07: slave follows credentials, or all when set
// RULE_08: interlock group must be closed and locked
// RULE_09: lock output held for activation time
// RULE_10: zero time toggles latch, disables exit/entry
// RULE_11: lock activation time capped at 128 s
// RULE_12: alarm outputs pulse on/off in 100 ms
// RULE_13: zero on or off count means steady on
// RULE_14: pulse counts up to 255 units
// RULE_15: open without access raises forced alarm
// RULE_16: forced delay holds off forced state
// RULE_17: door position sense with invert option
// RULE_18: exit request unlocks for lock time; exit_time used instead when CTRL_EXIT_TIME_EN is set
// RULE_19: one common tick, timers idle at reset
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "door_supervision_consts.vh"
module door_supervision_timers #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        door_contact,
  input  wire        exit_request,
  input  wire        entry_request,
  input  wire        schedule_valid,
  input  wire        interlock_clear,
  output reg         lock_out,
  output reg         slave_lock_out,
  output reg         pre_alarm_out,
  output reg         left_open_out,
  output reg         forced_open_out,
  output reg         left_open_trouble,
  output reg         forced_trouble,
  output reg         irq
);

////////////////////////////////////////////////////////////////////////////////
// reset release and input synchronisers
reg [1:0] rst_sync;
wire      rst_core_n = rst_sync[1];
always @(posedge core_clk or negedge rst_n)
begin
  if (!rst_n) rst_sync <= 2'b00;
  else        rst_sync <= {rst_sync[0], 1'b1};
end

reg [4:0] in_meta;
reg [4:0] in_sync;
reg [4:0] in_prev;
always @(posedge core_clk or negedge rst_core_n)
begin
  if (!rst_core_n)
  begin
    in_meta <= 5'b0_0000;
    in_sync <= 5'b0_0000;
    in_prev <= 5'b0_0000;
  end
  else
  begin
    in_meta <= {interlock_clear, schedule_valid, entry_request, exit_request, door_contact};
    in_sync <= in_meta;
    in_prev <= in_sync;
  end
end

////////////////////////////////////////////////////////////////////////////////
// registers
reg  [4:0]  ctrl;
reg  [7:0]  lock_time;
reg  [7:0]  exit_time;
reg  [7:0]  pre_delay;
reg  [7:0]  left_delay;
reg  [7:0]  forced_delay;
reg  [15:0] pre_pulse;
reg  [15:0] left_pulse;
reg  [15:0] forced_pulse;
reg  [4:0]  irq_status;
reg  [4:0]  irq_mask;
reg  [3:0]  cmd_pulse;
wire        wr = psel & penable & pwrite;
wire        rd = psel & penable & ~pwrite;
wire        door_open = in_sync[0] ^ ctrl[`CTRL_INVERT_DOOR]; // RULE_17
reg         latched;
reg  [4:0]  events;

assign pready  = 1'b1;
assign pslverr = 1'b0;

// clamp a lock time to the documented ceiling
function [7:0] clamp_lock;
  input [7:0] v;
  begin
    clamp_lock = (v > `MAX_LOCK_TIME) ? `MAX_LOCK_TIME : v; // RULE_11
  end
endfunction

// register writes and sticky event flags
always @(posedge core_clk or negedge rst_core_n)
begin
  if (!rst_core_n)
  begin
    ctrl         <= 5'b0_0000;
    lock_time    <= `RST_LOCK_TIME;
    exit_time    <= `RST_EXIT_TIME;
    pre_delay    <= `RST_PRE_DELAY; // RULE_04
    left_delay   <= `RST_LEFT_DELAY; // RULE_04
    forced_delay <= `RST_FORCED_DELAY;
    pre_pulse    <= 16'h0000;
    left_pulse   <= 16'h0000;
    forced_pulse <= 16'h0000;
    irq_mask     <= 5'b0_0000;
    irq_status   <= 5'b0_0000;
    cmd_pulse    <= 4'h0;
  end
  else
  begin
    cmd_pulse <= 4'h0;
    if (wr)
    begin
      case (paddr)
        `REG_CTRL:         ctrl <= pwdata[4:0];
        `REG_LOCK_TIME:
        begin
          lock_time <= clamp_lock(pwdata[7:0]);
          exit_time <= clamp_lock(pwdata[15:8]);
        end
        `REG_ALARM_TIME:
        begin
          pre_delay    <= pwdata[7:0];
          left_delay   <= pwdata[15:8];
          forced_delay <= pwdata[23:16];
        end
        `REG_PRE_PULSE:    pre_pulse <= pwdata[15:0];
        `REG_LEFT_PULSE:   left_pulse <= pwdata[15:0];
        `REG_FORCED_PULSE: forced_pulse <= pwdata[15:0];
        `REG_CMD:          cmd_pulse <= pwdata[3:0];
        `REG_IRQ_MASK:     irq_mask <= pwdata[4:0];
        default:           cmd_pulse <= 4'h0;
      endcase
    end
    // set wins over read clear
    if (rd && paddr == `REG_IRQ_STATUS) irq_status <= events;
    else                                irq_status <= irq_status | events;
    irq <= |((irq_status | events) & irq_mask);
  end
end

// read mux
always @*
begin
  prdata = 32'h0000_0000;
  case (paddr)
    `REG_CTRL:         prdata = {27'h000_0000, ctrl};
    `REG_LOCK_TIME:    prdata = {16'h0000, exit_time, lock_time};
    `REG_ALARM_TIME:   prdata = {8'h00, forced_delay, left_delay, pre_delay};
    `REG_PRE_PULSE:    prdata = {16'h0000, pre_pulse};
    `REG_LEFT_PULSE:   prdata = {16'h0000, left_pulse};
    `REG_FORCED_PULSE: prdata = {16'h0000, forced_pulse};
    `REG_STATUS:       prdata = {24'h00_0000, slave_lock_out, latched, lock_out,
                                 forced_open_out, left_open_out, pre_alarm_out,
                                 1'b0, door_open};
    `REG_IRQ_STATUS:   prdata = {27'h000_0000, irq_status};
    `REG_IRQ_MASK:     prdata = {27'h000_0000, irq_mask};
    default:           prdata = 32'h0000_0000;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// common timebase: 100 ms tick and 1 s tick
reg [31:0] tick_cnt;
reg [3:0]  sec_cnt;
reg        tick;
reg        sec_tick;
always @(posedge core_clk or negedge rst_core_n)
begin
  if (!rst_core_n)
  begin
    tick_cnt <= 32'h0000_0000;
    sec_cnt  <= 4'h0;
    tick     <= 1'b0;
    sec_tick <= 1'b0;
  end
  else
  begin
    tick     <= 1'b0;
    sec_tick <= 1'b0;
    if (tick_cnt == TICK_CYCLES - 1) // RULE_19
    begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
      if (sec_cnt == `TICKS_PER_SEC - 1)
      begin
        sec_cnt  <= 4'h0;
        sec_tick <= 1'b1;
      end
      else
        sec_cnt <= sec_cnt + 4'h1;
    end
    else
      tick_cnt <= tick_cnt + 32'h0000_0001;
  end
end

////////////////////////////////////////////////////////////////////////////////
// lock control
wire door_opened = door_open & ~(in_prev[0] ^ ctrl[`CTRL_INVERT_DOOR]);
wire exit_rise   = in_sync[1] & ~in_prev[1];
wire entry_rise  = in_sync[2] & ~in_prev[2];
wire sched_rise  = in_sync[3] & ~in_prev[3];
wire sched_fall  = ~in_sync[3] & in_prev[3];
wire ilock_ok    = ~ctrl[`CTRL_INTERLOCK] | in_sync[4];             // RULE_08
wire zero_time   = (lock_time == 8'h00);
wire cred_req    = cmd_pulse[`CMD_CRED_UNLOCK] & ilock_ok;
wire man_req     = cmd_pulse[`CMD_MANUAL_UNLOCK] & ilock_ok;
wire req_req     = (exit_rise | entry_rise) & ~zero_time & ilock_ok; // RULE_10
wire user_req    = cred_req | man_req;
wire any_unlock  = user_req | req_req;
// exit and entry requests carry no user, so they need no rights strobe
wire slave_user  = cmd_pulse[`CMD_SLAVE_RIGHTS] &
                   (cred_req | (ctrl[`CTRL_SLAVE_ALL] & man_req));            // RULE_06
wire slave_go    = ctrl[`CTRL_SLAVE_ASSIGN] &
                   (slave_user | (ctrl[`CTRL_SLAVE_ALL] & req_req));         // RULE_07
reg  [7:0] lock_sec;
reg  [7:0] slave_sec;
reg        granted;

// timed and latched unlock of the primary door, timed unlock of the slave door
always @(posedge core_clk or negedge rst_core_n)
begin
  if (!rst_core_n)
  begin
    lock_sec       <= 8'h00;
    slave_sec      <= 8'h00;
    latched        <= 1'b0;
    lock_out       <= 1'b0;
    slave_lock_out <= 1'b0;
    granted        <= 1'b0;
  end
  else
  begin
    if (sched_rise && ilock_ok) latched <= 1'b1;                     // RULE_05
    else if (sched_fall || cmd_pulse[`CMD_LOCK]) latched <= 1'b0;    // RULE_05
    else if (user_req && zero_time) latched <= ~latched;             // RULE_10
    if (any_unlock && !zero_time)
      lock_sec <= (exit_rise && ctrl[`CTRL_EXIT_TIME_EN]) ? exit_time : lock_time; // RULE_18
    else if (sec_tick && lock_sec != 8'h00)
      lock_sec <= lock_sec - 8'h01;                                  // RULE_09
    if (slave_go)
      slave_sec <= zero_time ? {7'h00, ~latched} : lock_time;        // RULE_06
    else if (sec_tick && slave_sec != 8'h00)
      slave_sec <= slave_sec - 8'h01;
    lock_out       <= latched | (lock_sec != 8'h00);
    slave_lock_out <= slave_sec != 8'h00;
    // access granted while unlocked, withdrawn once door shuts
    if (latched || lock_sec != 8'h00 || any_unlock) granted <= 1'b1;
    else if (!door_open) granted <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// door open timers and alarm states
reg [8:0] open_sec;
reg       pre_on;
reg       left_on;
reg       forced_pend;
reg       forced_on;
always @(posedge core_clk or negedge rst_core_n)
begin
  if (!rst_core_n)
  begin
    open_sec    <= 9'h000;
    pre_on      <= 1'b0;
    left_on     <= 1'b0;
    forced_pend <= 1'b0;
    forced_on   <= 1'b0;
    events      <= 5'b0_0000;
  end
  else
  begin
    events <= 5'b0_0000;
    events[`EV_OPEN]  <= door_opened;
    events[`EV_CLOSE] <= ~door_open & (in_prev[0] ^ ctrl[`CTRL_INVERT_DOOR]);
    if (!door_open)
    begin
      open_sec    <= 9'h000;
      pre_on      <= 1'b0;
      left_on     <= 1'b0;
      forced_pend <= 1'b0;
      forced_on   <= 1'b0;
    end
    else
    begin
      // one counter from door opening drives all three alarms
      // strictly past the delay, so a part second never fires early
      if (sec_tick && open_sec != 9'h1FF) open_sec <= open_sec + 9'h001; // RULE_03
      if (!pre_on && open_sec > {1'b0, pre_delay} && pre_delay != 8'h00)
      begin
        pre_on         <= 1'b1;                                        // RULE_01
        events[`EV_PRE] <= 1'b1;                                       // RULE_01
      end
      if (!left_on && open_sec > {1'b0, left_delay} && left_delay != 8'h00)
      begin
        left_on          <= 1'b1;                                      // RULE_02
        events[`EV_LEFT] <= 1'b1;                                      // RULE_02
      end
      // forced delay timed from the opening, never shorter than set
      if (door_opened && !granted)
        forced_pend <= 1'b1;                                           // RULE_15
      else if (forced_pend && !forced_on &&
               (forced_delay == 8'h00 || open_sec > {1'b0, forced_delay})) // RULE_16
      begin
        forced_on          <= 1'b1;                                    // RULE_15
        events[`EV_FORCED] <= 1'b1;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// alarm output pulsing in 100 ms units
reg [8:0] pre_ph;
reg [8:0] left_ph;
reg [8:0] forced_ph;

// next phase count: cycles on then off, wraps at on+off
function [8:0] next_phase;
  input       act;
  input [15:0] cfg;
  input [8:0] ph;
  begin
    if (!act)
      next_phase = 9'h000;
    else if (ph + 9'h001 >= {1'b0, cfg[7:0]} + {1'b0, cfg[15:8]})
      next_phase = 9'h000;                                             // RULE_12
    else
      next_phase = ph + 9'h001;                                        // RULE_14
  end
endfunction

// level for phase: steady on when either count is zero
function pulse_level;
  input       act;
  input [15:0] cfg;
  input [8:0] ph;
  begin
    pulse_level = act & ((cfg[7:0] == 8'h00) | (cfg[15:8] == 8'h00) | // RULE_13
                         (ph < {1'b0, cfg[7:0]}));                     // RULE_12
  end
endfunction

always @(posedge core_clk or negedge rst_core_n)
begin
  if (!rst_core_n)
  begin
    pre_ph            <= 9'h000;
    left_ph           <= 9'h000;
    forced_ph         <= 9'h000;
    pre_alarm_out     <= 1'b0;
    left_open_out     <= 1'b0;
    forced_open_out   <= 1'b0;
    left_open_trouble <= 1'b0;
    forced_trouble    <= 1'b0;
  end
  else
  begin
    if (tick || !pre_on)    pre_ph <= next_phase(pre_on, pre_pulse, pre_ph);
    if (tick || !left_on)   left_ph <= next_phase(left_on, left_pulse, left_ph);
    if (tick || !forced_on) forced_ph <= next_phase(forced_on, forced_pulse, forced_ph);
    pre_alarm_out     <= pulse_level(pre_on, pre_pulse, pre_ph);       // RULE_01
    left_open_out     <= pulse_level(left_on, left_pulse, left_ph);    // RULE_02
    forced_open_out   <= pulse_level(forced_on, forced_pulse, forced_ph); // RULE_15
    left_open_trouble <= left_on;                                      // RULE_02
    forced_trouble    <= forced_on;                                    // RULE_15
  end
end

endmodule // door_supervision_timers

// File: tb/door_partner.sv
`timescale 1ns/1ns
// door contact sensor: reed opens once the leaf has travelled
module door_partner (
  input  wire core_clk,
  input  wire leaf_open,
  output wire door_contact
);
  reg [2:0] travel = 3'h0;
  reg       reed   = 1'b0;
  assign door_contact = reed;
  // three cycles of leaf travel, then the reed reacts on the fourth edge
  always @(posedge core_clk)
  begin
    travel <= {travel[1:0], leaf_open};
    reed   <= travel[2];
  end
endmodule // door_partner

// File: tb/door_supervision_timers_assertions.sv
`timescale 1ns/1ns
// timing relations between door block ports
module door_supervision_timers_assertions (
  input wire        core_clk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        schedule_valid,
  input wire        interlock_clear,
  input wire        lock_out,
  input wire        slave_lock_out,
  input wire        pre_alarm_out,
  input wire        left_open_out,
  input wire        forced_open_out,
  input wire        left_open_trouble,
  input wire        forced_trouble,
  input wire        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  property p_rst_idle;
    $rose(rst_n) |-> !(lock_out | slave_lock_out | pre_alarm_out | left_open_out
      | forced_open_out | irq) [*2];
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs active after reset");
  property p_forced_trb;
    $rose(forced_open_out) |-> ##[0:2] forced_trouble;
  endproperty
  a_forced_trb: assert property (p_forced_trb)
    else $error("forced trouble missing");
  property p_left_trb;
    $rose(left_open_out) |-> ##[0:2] left_open_trouble;
  endproperty
  a_left_trb: assert property (p_left_trb)
    else $error("left open trouble missing");
  property p_sched_on;
    $rose(schedule_valid) && interlock_clear |-> ##[1:8] lock_out;
  endproperty
  a_sched_on: assert property (p_sched_on)
    else $error("schedule start did not unlock");
  property p_sched_off;
    $fell(schedule_valid) |-> ##[1:8] !lock_out;
  endproperty
  a_sched_off: assert property (p_sched_off)
    else $error("schedule end did not lock");
  property p_slave;
    $rose(slave_lock_out) |-> lock_out;
  endproperty
  a_slave: assert property (p_slave)
    else $error("slave unlocked without primary");
  property p_apb_ok;
    psel && penable |-> pready && !pslverr;
  endproperty
  a_apb_ok: assert property (p_apb_ok)
    else $error("apb wait or error seen");
  property p_unmapped;
    psel && penable && !pwrite && paddr > 12'h024 |-> prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule // door_supervision_timers_assertions
bind door_supervision_timers door_supervision_timers_assertions chk_i (
  .core_clk          (core_clk),
  .rst_n             (rst_n),
  .psel              (psel),
  .penable           (penable),
  .pwrite            (pwrite),
  .paddr             (paddr),
  .prdata            (prdata),
  .pready            (pready),
  .pslverr           (pslverr),
  .schedule_valid    (schedule_valid),
  .interlock_clear   (interlock_clear),
  .lock_out          (lock_out),
  .slave_lock_out    (slave_lock_out),
  .pre_alarm_out     (pre_alarm_out),
  .left_open_out     (left_open_out),
  .forced_open_out   (forced_open_out),
  .left_open_trouble (left_open_trouble),
  .forced_trouble    (forced_trouble),
  .irq               (irq)
);

// File: tb/test_door_supervision_timers.sv
`timescale 1ns/1ns
`include "door_supervision_consts.vh"
module test_door_supervision_timers;
  reg         core_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0000_0000;
  reg         exit_request = 1'b0;
  reg         entry_request = 1'b0;
  reg         schedule_valid = 1'b0;
  reg         interlock_clear = 1'b1;
  reg         leaf_open = 1'b0;
  wire [31:0] prdata;
  wire        pready, pslverr, door_contact, lock_out, slave_lock_out;
  wire        pre_alarm_out, left_open_out, forced_open_out, left_open_trouble;
  wire        forced_trouble, irq;
  wire [2:0]  alarms = {forced_open_out, left_open_out, pre_alarm_out};
  integer     num_errors = 0;
  integer     checks = 0;
  integer     i, n, t, t0;
  reg  [31:0] rd;
  reg  [75:0] rows [0:6];
  ////////////////////////////////////////
  // 50 MHz clock, 1 s is 100 cycles with a 10 cycle tick
  always #10 core_clk = ~core_clk;
  door_partner door_partner_i (
    .core_clk     (core_clk),
    .leaf_open    (leaf_open),
    .door_contact (door_contact)
  );
  door_supervision_timers #(.TICK_CYCLES(10)) door_supervision_timers_i (
    .core_clk          (core_clk),
    .rst_n             (rst_n),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .door_contact      (door_contact),
    .exit_request      (exit_request),
    .entry_request     (entry_request),
    .schedule_valid    (schedule_valid),
    .interlock_clear   (interlock_clear),
    .lock_out          (lock_out),
    .slave_lock_out    (slave_lock_out),
    .pre_alarm_out     (pre_alarm_out),
    .left_open_out     (left_open_out),
    .forced_open_out   (forced_open_out),
    .left_open_trouble (left_open_trouble),
    .forced_trouble    (forced_trouble),
    .irq               (irq)
  );
  ////////////////////////////////////////
  // one apb transfer, read data kept in rd
  task bus(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  // compare and count
  task chk(input string nm, input [31:0] e, input [31:0] s);
  begin
    checks = checks + 1;
    if (s !== e)
    begin
      num_errors = num_errors + 1;
      $display("Error %0s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  // wait cycles, settle at falling edge
  task cyc(input integer k);
  begin
    repeat (k) @(posedge core_clk);
    @(negedge core_clk);
  end
  endtask
  // wait for an alarm output level, n counts edges
  task wait_lvl(input integer k, input v, input integer lim);
  begin
    n = 0;
    while (alarms[k] !== v && n < lim)
    begin
      @(negedge core_clk);
      n = n + 1;
    end
  end
  endtask
  // exit or entry button press
  task pulse(input ent);
  begin
    @(posedge core_clk);
    exit_request <= !ent;
    entry_request <= ent;
    repeat (5) @(posedge core_clk);
    exit_request <= 1'b0;
    entry_request <= 1'b0;
  end
  endtask
  // reset held 8 cycles
  task do_reset;
  begin
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(3);
    chk("idle", 0, {lock_out, slave_lock_out, forced_open_out, forced_trouble, irq});
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  ////////////////////////////////////////
  // watchdog
  initial
  begin
    #400000;
    num_errors = num_errors + 1;
    report_and_stop;
  end
  // main sequence
  initial
  begin
    rows[0] = {`REG_LOCK_TIME, 32'h0000_03C8, 32'h0000_0380};
    rows[1] = {`REG_LOCK_TIME, 32'h0000_0580, 32'h0000_0580};
    rows[2] = {`REG_PRE_PULSE, 32'h0000_0802, 32'h0000_0802};
    rows[3] = {`REG_LEFT_PULSE, 32'h0000_FFFF, 32'h0000_FFFF};
    rows[4] = {`REG_FORCED_PULSE, 32'h0000_0000, 32'h0000_0000};
    rows[5] = {12'h040, 32'hFFFF_FFFF, 32'h0000_0000};
    rows[6] = {`REG_IRQ_MASK, 32'h0000_0004, 32'h0000_0004};
    do_reset;
    bus(0, `REG_ALARM_TIME, 0);
    chk("alarm_time", 32'h0000_2D1E, rd);
    for (i = 0; i < 7; i = i + 1)
    begin
      bus(1, rows[i][75:64], rows[i][63:32]);
      bus(0, rows[i][75:64], 0);
      chk("row", rows[i][31:0], rd);
    end
    // timed unlock with slave door
    bus(1, `REG_LOCK_TIME, 32'h0000_0202);
    bus(1, `REG_CTRL, 32'h0000_0004);
    bus(1, `REG_CMD, 32'h0000_0009);
    cyc(4);
    chk("slave", 1, slave_lock_out);
    cyc(90);
    chk("lock_on", 1, lock_out);
    cyc(130);
    chk("lock_off", 0, lock_out);
    pulse(0);
    cyc(4);
    chk("exit", 1, lock_out);
    chk("slave_exit", 0, slave_lock_out);
    cyc(220);
    bus(1, `REG_CTRL, 32'h0000_0016);
    bus(1, `REG_LOCK_TIME, 32'h0000_0402);
    pulse(0);
    cyc(4);
    chk("slave_all", 1, slave_lock_out);
    cyc(250);
    chk("exit_time", 1, lock_out);
    cyc(220);
    // zero lock time toggles a latch
    bus(1, `REG_CTRL, 0);
    bus(1, `REG_LOCK_TIME, 32'h0000_0200);
    bus(1, `REG_CMD, 32'h0000_0002);
    cyc(300);
    chk("latch", 1, lock_out);
    bus(1, `REG_CMD, 32'h0000_0002);
    cyc(4);
    chk("unlatch", 0, lock_out);
    pulse(1);
    cyc(4);
    chk("entry_off", 0, lock_out);
    // interlock group
    bus(1, `REG_LOCK_TIME, 32'h0000_0202);
    bus(1, `REG_CTRL, 32'h0000_0008);
    @(posedge core_clk) interlock_clear <= 1'b0;
    bus(1, `REG_CMD, 32'h0000_0001);
    cyc(4);
    chk("blocked", 0, lock_out);
    @(posedge core_clk) interlock_clear <= 1'b1;
    bus(1, `REG_CMD, 32'h0000_0001);
    cyc(4);
    chk("unblocked", 1, lock_out);
    cyc(220);
    // schedule latch and operator override
    @(posedge core_clk) schedule_valid <= 1'b1;
    cyc(300);
    chk("sched", 1, lock_out);
    bus(1, `REG_CMD, 32'h0000_0004);
    cyc(4);
    chk("override", 0, lock_out);
    @(posedge core_clk) schedule_valid <= 1'b0;
    // forced open with 2 s delay, interrupt
    bus(1, `REG_ALARM_TIME, 32'h0002_2D1E);
    @(posedge core_clk) leaf_open <= 1'b1;
    cyc(150);
    chk("forced_hold", 0, forced_open_out);
    wait_lvl(2, 1, 400);
    cyc(2);
    chk("forced", 1, forced_open_out);
    chk("irq", 1, irq);
    bus(0, `REG_IRQ_STATUS, 0);
    chk("irq_status", 32'h0000_000C, rd);
    cyc(2);
    chk("irq_clear", 0, irq);
    cyc(50);
    chk("steady", 1, forced_open_out);
    @(posedge core_clk) leaf_open <= 1'b0;
    cyc(10);
    bus(1, `REG_CTRL, 32'h0000_0001);
    cyc(6);
    bus(0, `REG_STATUS, 0);
    chk("inverted", 1, rd[0]);
    // default pre-alarm and left-open timing after a second reset
    do_reset;
    bus(1, `REG_PRE_PULSE, 32'h0000_0802);
    bus(1, `REG_CMD, 32'h0000_0001);
    @(posedge core_clk) leaf_open <= 1'b1;
    t0 = $time;
    wait_lvl(0, 1, 4000);
    t = ($time - t0) / 20;
    chk("pre_time", 1, t > 2880 && t < 3120);
    wait_lvl(0, 0, 100);
    wait_lvl(0, 1, 200);
    chk("pre_off", 80, n);
    wait_lvl(0, 0, 100);
    chk("pre_on", 20, n);
    wait_lvl(1, 1, 2000);
    t = ($time - t0) / 20;
    chk("left_time", 1, t > 4380 && t < 4620);
    cyc(3);
    chk("left_trouble", 1, left_open_trouble);
    report_and_stop;
  end
endmodule // test_door_supervision_timers
